/* File: rtl/logical_layer_error_capture.v */
/*
 * logical/transport layer error capture: detect flags, enables,
 * maintenance interrupt and lockable capture registers for the
 * offending packet's address, device ids and control fields.
 * assumes all inputs but the asynchronous i_rst_n are synchronous to i_clk_sys, error inputs are
 * one-cycle pulses presented together with the packet fields on the
 * i_pkt_* bus, and software uses the plain register port.
 */
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "lte_capture_consts.vh"

module logical_layer_error_capture
(
   // clock and reset
   input wire i_clk_sys,
   input wire i_rst_n,
   // register port
   input wire [`LTE_ADDR_W-1:0] i_reg_addr,
   input wire [`LTE_DATA_W-1:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   output reg [`LTE_DATA_W-1:0] o_reg_rdata,
   output reg o_reg_rvalid,
   // error event pulses from the packet engines
   input wire i_rw_request_error_response,
   input wire i_message_request_error_response,
   input wire i_message_payload_format_fault,
   input wire i_illegal_field_decode,
   input wire i_undefined_destination_target,
   input wire i_message_segment_timeout,
   input wire i_response_wait_timeout,
   input wire i_unexpected_response,
   input wire i_unsupported_transaction,
   // fields of the packet that goes with an error pulse
   input wire [31:0] i_pkt_address,
   input wire [1:0] i_pkt_extended_address_high_bits,
   input wire [7:0] i_pkt_target_id,
   input wire [7:0] i_pkt_origin_id,
   input wire [3:0] i_pkt_format_kind,
   input wire [3:0] i_pkt_transaction_kind,
   input wire [7:0] i_pkt_mailbox_info,
   // pulse marking a received message request segment on i_pkt_*
   input wire i_msg_segment_seen,
   // status
   output reg o_maint_irq,
   output reg o_capture_locked
);

   // software-visible state
   reg [31:0] detect_reg;
   reg [31:0] detect_next;
   reg [31:0] enable_reg;
   reg [31:0] enable_next;
   reg [28:0] captured_address_reg;
   reg [1:0] extended_address_high_bits_reg;
   reg [7:0] captured_target_id_reg;
   reg [7:0] captured_origin_id_reg;
   reg [3:0] captured_format_kind_reg;
   reg [3:0] captured_transaction_kind_reg;
   reg [7:0] captured_mailbox_info_reg;
   reg lock_reg;
   reg lock_next;

   // shadow of the most recent message request segment
   reg [7:0] seg_target_id_reg;
   reg [7:0] seg_origin_id_reg;
   reg [3:0] seg_format_kind_reg;
   reg [3:0] seg_transaction_kind_reg;
   reg [7:0] seg_mailbox_info_reg;

   // read path
   reg [31:0] rd_next;

   // decode and event wires
   wire wr_detect;
   wire wr_enable;
   wire clearing_write;
   wire [31:0] event_vec;
   wire [31:0] enabled_hit;
   wire grp_full;
   wire grp_idctl;
   wire grp_seg_timeout;
   wire grp_rsp_timeout;
   wire capture_go;

   // register write decode
   assign wr_detect = i_reg_wr && (i_reg_addr == `LTE_DETECT_OFS);
   assign wr_enable = i_reg_wr && (i_reg_addr == `LTE_ENABLE_OFS);

   // a detect write that leaves no bit set is the software clear
   assign clearing_write = wr_detect && ((i_reg_wdata & `LTE_ERR_MASK) == 32'h00000000);

   // error pulses placed at their detect positions
   assign event_vec[`LTE_BIT_RW_ERR_RSP] = i_rw_request_error_response;
   assign event_vec[`LTE_BIT_MSG_ERR_RSP] = i_message_request_error_response;
   assign event_vec[29] = 1'b0;
   assign event_vec[`LTE_BIT_MSG_FORMAT] = i_message_payload_format_fault;
   assign event_vec[`LTE_BIT_ILL_DECODE] = i_illegal_field_decode;
   assign event_vec[`LTE_BIT_ILL_TARGET] = i_undefined_destination_target;
   assign event_vec[`LTE_BIT_MSG_TIMEOUT] = i_message_segment_timeout;
   assign event_vec[`LTE_BIT_RSP_TIMEOUT] = i_response_wait_timeout;
   assign event_vec[`LTE_BIT_UNEXP_RSP] = i_unexpected_response;
   assign event_vec[`LTE_BIT_UNSUP_TRAN] = i_unsupported_transaction;
   assign event_vec[21:0] = 22'h000000;

   // only enabled errors take part in capture
   assign enabled_hit = event_vec & enable_reg;

   // capture groups by which registers they load
   assign grp_full = enabled_hit[`LTE_BIT_RW_ERR_RSP] |
                     enabled_hit[`LTE_BIT_MSG_ERR_RSP] |
                     enabled_hit[`LTE_BIT_MSG_FORMAT];
   assign grp_idctl = enabled_hit[`LTE_BIT_ILL_DECODE] |
                      enabled_hit[`LTE_BIT_ILL_TARGET] |
                      enabled_hit[`LTE_BIT_UNEXP_RSP] |
                      enabled_hit[`LTE_BIT_UNSUP_TRAN];
   assign grp_seg_timeout = enabled_hit[`LTE_BIT_MSG_TIMEOUT];
   assign grp_rsp_timeout = enabled_hit[`LTE_BIT_RSP_TIMEOUT];

   // capture when armed, or in the very cycle software re-arms
   assign capture_go = (grp_full | grp_idctl | grp_seg_timeout | grp_rsp_timeout) &&
                       (!lock_reg || clearing_write);

   // detect update: software write first, hardware set wins over it
   always @*
   begin
      detect_next = detect_reg;
      if (wr_detect)
      begin
         detect_next = i_reg_wdata & `LTE_ERR_MASK;
      end
      detect_next = detect_next | event_vec;
   end

   // enable update, reserved bits dropped
   always @*
   begin
      enable_next = enable_reg;
      if (wr_enable)
      begin
         enable_next = i_reg_wdata & `LTE_ERR_MASK;
      end
   end

   // lock: set by a capture, released by the software clear
   always @*
   begin
      lock_next = lock_reg;
      if (capture_go)
      begin
         lock_next = 1'b1;
      end
      else if (clearing_write)
      begin
         lock_next = 1'b0;
      end
   end

   // detect, enable, lock and interrupt flops
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         detect_reg <= `LTE_REG_RESET;
         enable_reg <= `LTE_REG_RESET;
         lock_reg <= 1'b0;
         o_capture_locked <= 1'b0;
         o_maint_irq <= 1'b0;
      end
      else
      begin
         detect_reg <= detect_next;
         enable_reg <= enable_next;
         lock_reg <= lock_next;
         o_capture_locked <= lock_next;
         o_maint_irq <= |(detect_next & enable_next);
      end
   end

   // shadow of the last message request segment for the timeout case
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         seg_target_id_reg <= `LTE_ZERO_8;
         seg_origin_id_reg <= `LTE_ZERO_8;
         seg_format_kind_reg <= `LTE_ZERO_4;
         seg_transaction_kind_reg <= `LTE_ZERO_4;
         seg_mailbox_info_reg <= `LTE_ZERO_8;
      end
      else if (i_msg_segment_seen)
      begin
         seg_target_id_reg <= i_pkt_target_id;
         seg_origin_id_reg <= i_pkt_origin_id;
         seg_format_kind_reg <= i_pkt_format_kind;
         seg_transaction_kind_reg <= i_pkt_transaction_kind;
         seg_mailbox_info_reg <= i_pkt_mailbox_info;
      end
   end

   // capture registers; a fixed priority picks one source per capture
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         captured_address_reg <= 29'h00000000;
         extended_address_high_bits_reg <= 2'h0;
         captured_target_id_reg <= `LTE_ZERO_8;
         captured_origin_id_reg <= `LTE_ZERO_8;
         captured_format_kind_reg <= `LTE_ZERO_4;
         captured_transaction_kind_reg <= `LTE_ZERO_4;
         captured_mailbox_info_reg <= `LTE_ZERO_8;
      end
      else if (capture_go)
      begin
         if (grp_full)
         begin
            // error responses and format faults load every register
            captured_address_reg <= i_pkt_address[`LTE_ADDR_HI:`LTE_ADDR_LO];
            extended_address_high_bits_reg <= i_pkt_extended_address_high_bits;
            captured_target_id_reg <= i_pkt_target_id;
            captured_origin_id_reg <= i_pkt_origin_id;
            captured_format_kind_reg <= i_pkt_format_kind;
            captured_transaction_kind_reg <= i_pkt_transaction_kind;
            captured_mailbox_info_reg <= i_pkt_mailbox_info;
         end
         else if (grp_idctl)
         begin
            // decode, target, unexpected and unsupported: ids and control
            captured_target_id_reg <= i_pkt_target_id;
            captured_origin_id_reg <= i_pkt_origin_id;
            captured_format_kind_reg <= i_pkt_format_kind;
            captured_transaction_kind_reg <= i_pkt_transaction_kind;
            captured_mailbox_info_reg <= i_pkt_mailbox_info;
         end
         else if (grp_seg_timeout)
         begin
            // segment timeout: from the last segment actually seen
            captured_target_id_reg <= seg_target_id_reg;
            captured_origin_id_reg <= seg_origin_id_reg;
            captured_format_kind_reg <= seg_format_kind_reg;
            captured_transaction_kind_reg <= seg_transaction_kind_reg;
            captured_mailbox_info_reg <= seg_mailbox_info_reg;
         end
         else
         begin
            // response timeout: original address and destination, source id cleared
            captured_address_reg <= i_pkt_address[`LTE_ADDR_HI:`LTE_ADDR_LO];
            extended_address_high_bits_reg <= i_pkt_extended_address_high_bits;
            captured_target_id_reg <= i_pkt_target_id;
            captured_origin_id_reg <= `LTE_ZERO_8; // no source for a lost response
         end
      end
   end

   // read data mux; reserved and unmapped read as zero
   always @*
   begin
      rd_next = 32'h00000000;
      case (i_reg_addr)
         `LTE_DETECT_OFS:
         begin
            rd_next = detect_reg;
         end
         `LTE_ENABLE_OFS:
         begin
            rd_next = enable_reg;
         end
         `LTE_ADDR_CAP_OFS:
         begin
            rd_next[`LTE_ADDR_HI:`LTE_ADDR_LO] = captured_address_reg;
            rd_next[`LTE_XADDR_HI:`LTE_XADDR_LO] = extended_address_high_bits_reg;
         end
         `LTE_DEVID_CAP_OFS:
         begin
            rd_next[`LTE_DEST_HI:`LTE_DEST_LO] = captured_target_id_reg;
            rd_next[`LTE_SRC_HI:`LTE_SRC_LO] = captured_origin_id_reg;
         end
         `LTE_CTRL_CAP_OFS:
         begin
            rd_next[`LTE_CAPTURED_FORMAT_KIND_HI:`LTE_CAPTURED_FORMAT_KIND_LO] = captured_format_kind_reg;
            rd_next[`LTE_CAPTURED_TRANSACTION_KIND_HI:`LTE_CAPTURED_TRANSACTION_KIND_LO] = captured_transaction_kind_reg;
            rd_next[`LTE_INFO_HI:`LTE_INFO_LO] = captured_mailbox_info_reg;
         end
         default:
         begin
            rd_next = 32'h00000000;
         end
      endcase
   end

   // read data registered: valid only in the cycle after the strobe
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_reg_rdata <= 32'h00000000;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd)
         begin
            o_reg_rdata <= rd_next;
         end
         else
         begin
            o_reg_rdata <= 32'h00000000; // data only stands after a read
         end
      end
   end

endmodule // logical_layer_error_capture

/* File: shared/lte_capture_consts.vh */
/*
 * constants for the logical/transport layer error capture block:
 * register byte offsets, detect/enable bit positions, field layouts
 * and reset values.
 * assumes a 20-bit byte address on the register port and 32-bit data.
 */
`ifndef LTE_CAPTURE_CONSTS_VH
`define LTE_CAPTURE_CONSTS_VH

// register port widths
`define LTE_ADDR_W 20
`define LTE_DATA_W 32

// register byte offsets
`define LTE_DETECT_OFS 20'h10800
`define LTE_ENABLE_OFS 20'h10804
`define LTE_ADDR_CAP_OFS 20'h10808
`define LTE_DEVID_CAP_OFS 20'h1080c
`define LTE_CTRL_CAP_OFS 20'h10810

// detect and enable bit positions (same layout in both registers)
`define LTE_BIT_RW_ERR_RSP 31
`define LTE_BIT_MSG_ERR_RSP 30
`define LTE_BIT_MSG_FORMAT 28
`define LTE_BIT_ILL_DECODE 27
`define LTE_BIT_ILL_TARGET 26
`define LTE_BIT_MSG_TIMEOUT 25
`define LTE_BIT_RSP_TIMEOUT 24
`define LTE_BIT_UNEXP_RSP 23
`define LTE_BIT_UNSUP_TRAN 22

// implemented bits of detect and enable; others are reserved zero
`define LTE_ERR_MASK 32'hdfc00000

// address capture layout
`define LTE_ADDR_HI 31
`define LTE_ADDR_LO 3
`define LTE_XADDR_HI 1
`define LTE_XADDR_LO 0

// device id capture layout
`define LTE_DEST_HI 23
`define LTE_DEST_LO 16
`define LTE_SRC_HI 7
`define LTE_SRC_LO 0

// control capture layout
`define LTE_CAPTURED_FORMAT_KIND_HI 31
`define LTE_CAPTURED_FORMAT_KIND_LO 28
`define LTE_CAPTURED_TRANSACTION_KIND_HI 27
`define LTE_CAPTURED_TRANSACTION_KIND_LO 24
`define LTE_INFO_HI 23
`define LTE_INFO_LO 16

// reset values
`define LTE_REG_RESET 32'h00000000
`define LTE_ZERO_8 8'h00
`define LTE_ZERO_4 4'h0

`endif

/* File: tb/logical_layer_error_capture_bench.sv */
/*
 * self-checking bench: register tasks, read queue, every error kind.
 * assumes the packet engine model and the consts header.
 */
`timescale 1ns/1ps
`include "lte_capture_consts.vh"
module logical_layer_error_capture_bench;
   localparam logic [19:0] a_det = `LTE_DETECT_OFS;
   localparam logic [19:0] a_en = `LTE_ENABLE_OFS;
   localparam logic [31:0] m = `LTE_ERR_MASK;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b1;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic fire = 1'b0;
   logic seg = 1'b0;
   logic [3:0] kind = 4'h0;
   logic [19:0] i_reg_addr = 20'h0;
   logic [31:0] i_reg_wdata = 32'h0;
   wire [31:0] o_reg_rdata;
   wire o_reg_rvalid, o_maint_irq, o_capture_locked, seg_seen;
   wire [8:0] err;
   wire [65:0] pkt;
   logic [31:0] q[$];
   logic [31:0] ea = 32'h0, ed = 32'h0, ec = 32'h0;
   int error_cnt = 0;
   int n_tests = 0;
   int j;
   // 10 MHz clock
   always #50 i_clk_sys = ~i_clk_sys;
   logical_layer_error_capture dut
   (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_rw_request_error_response(err[8]), .i_message_request_error_response(err[7]),
      .i_message_payload_format_fault(err[6]), .i_illegal_field_decode(err[5]),
      .i_undefined_destination_target(err[4]), .i_message_segment_timeout(err[3]),
      .i_response_wait_timeout(err[2]), .i_unexpected_response(err[1]),
      .i_unsupported_transaction(err[0]), .i_pkt_address(pkt[65:34]),
      .i_pkt_extended_address_high_bits(pkt[33:32]), .i_pkt_target_id(pkt[31:24]),
      .i_pkt_origin_id(pkt[23:16]), .i_pkt_format_kind(pkt[15:12]),
      .i_pkt_transaction_kind(pkt[11:8]), .i_pkt_mailbox_info(pkt[7:0]),
      .i_msg_segment_seen(seg_seen), .o_maint_irq(o_maint_irq),
      .o_capture_locked(o_capture_locked)
   );
   lte_error_source src
   (
      .i_clk_sys(i_clk_sys), .i_fire(fire), .i_seg(seg), .i_kind(kind),
      .o_err(err), .o_seg(seg_seen), .o_pkt(pkt)
   );
   function automatic logic [31:0] bit_of(input int k);
      return 32'h1 << (k < 2 ? 31 - k : 30 - k);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // strobes stay up until idle, so transfers run back to back
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      i_reg_wr <= 1'b1;
      i_reg_rd <= 1'b0;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [19:0] a, input logic [31:0] exp);
      q.push_back(exp);
      i_reg_rd <= 1'b1;
      i_reg_wr <= 1'b0;
      i_reg_addr <= a;
      @(posedge i_clk_sys);
   endtask
   task automatic idle;
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   // returns at the edge where the block samples the pulse
   task automatic pulse(input logic f, input logic s, input int k);
      fire <= f;
      seg <= s;
      kind <= 4'(k);
      @(posedge i_clk_sys);
      fire <= 1'b0;
      seg <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic wrap_up;
      if (q.size() != 0) error_cnt++;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // answers are matched to the oldest note
   always @(posedge i_clk_sys)
   begin
      if (o_reg_rvalid === 1'b1 && q.size() > 0) chk(o_reg_rdata, q.pop_front());
      else if (o_reg_rvalid !== 1'b0) chk(32'h1, 32'h0);
   end
   // hang guard
   initial
   begin
      repeat (5000) @(posedge i_clk_sys);
      error_cnt++;
      wrap_up;
   end
   initial
   begin
      void'($urandom(28));
      // a real falling edge, so the asynchronous reset loads before the first clock
      i_rst_n <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      for (int k = 0; k < 6; k++) rd(a_det + 20'(4 * k), 32'h0);
      wr(a_en, 32'hffffffff);
      rd(a_en, m);
      wr(a_det, 32'hffffffff);
      rd(a_det, m);
      wr(`LTE_ADDR_CAP_OFS, 32'hffffffff);
      rd(`LTE_ADDR_CAP_OFS, 32'h0);
      idle;
      chk(o_maint_irq, 1'b1);
      chk(o_capture_locked, 1'b0);
      // every kind: capture, a later error while locked, then clear
      for (int k = 0; k < 9; k++)
      begin
         wr(a_det, 32'h0);
         idle;
         if (k == 5)
         begin
            pulse(1'b0, 1'b1, 0);
            ed = {8'h0, pkt[31:24], 8'h0, pkt[23:16]};
            ec = {pkt[15:0], 16'h0};
         end
         pulse(1'b1, 1'b0, k);
         if (k < 3 || k == 6) ea = {pkt[65:37], 1'b0, pkt[33:32]};
         if (k != 5 && k != 6) ed = {8'h0, pkt[31:24], 8'h0, pkt[23:16]};
         if (k != 5 && k != 6) ec = {pkt[15:0], 16'h0};
         if (k == 6) ed = {8'h0, pkt[31:24], 16'h0};
         j = $urandom % 9;
         pulse(1'b1, 1'b0, j);
         chk(o_capture_locked, 1'b1);
         chk(o_maint_irq, 1'b1);
         rd(a_det, bit_of(k) | bit_of(j));
         rd(`LTE_ADDR_CAP_OFS, ea);
         rd(`LTE_DEVID_CAP_OFS, ed);
         rd(`LTE_CTRL_CAP_OFS, ec);
         idle;
      end
      wr(a_det, 32'h0);
      idle;
      chk(o_capture_locked, 1'b0);
      chk(o_maint_irq, 1'b0);
      // disabled error: flag only, no capture
      wr(a_en, 32'h0);
      idle;
      pulse(1'b1, 1'b0, 0);
      @(posedge i_clk_sys);
      chk(o_maint_irq, 1'b0);
      chk(o_capture_locked, 1'b0);
      rd(a_det, 32'h80000000);
      wr(a_en, 32'h80000000);
      idle;
      chk(o_maint_irq, 1'b1);
      repeat (3) @(posedge i_clk_sys);
      wrap_up;
   end
endmodule // logical_layer_error_capture_bench

/* File: tb/lte_capture_props.sv */
/*
 * assertion checker for the error capture block, bound to its top.
 * assumes the consts header is on the include path.
 */
`timescale 1ns/1ps
`include "lte_capture_consts.vh"
module lte_capture_props
(
   // clock and reset
   input wire i_clk_sys,
   input wire i_rst_n,
   // register port
   input wire [19:0] i_reg_addr,
   input wire [31:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [31:0] o_reg_rdata,
   input wire o_reg_rvalid,
   // status
   input wire o_maint_irq,
   input wire o_capture_locked
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // software write that empties the detect register
   wire det_clr = i_reg_wr && i_reg_addr == `LTE_DETECT_OFS
      && (i_reg_wdata & `LTE_ERR_MASK) == 32'h0;
   chk_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read strobe without answer");
   chk_idle_quiet: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 32'h0)
      else $error("read data outside answer cycle");
   chk_detect_rsvd: assert property (i_reg_rd && i_reg_addr == `LTE_DETECT_OFS
      |=> (o_reg_rdata & ~`LTE_ERR_MASK) == 32'h0) else $error("detect reserved bit set");
   chk_devid_rsvd: assert property (i_reg_rd && i_reg_addr == `LTE_DEVID_CAP_OFS
      |=> o_reg_rdata[31:24] == 8'h0 && o_reg_rdata[15:8] == 8'h0)
      else $error("id capture reserved bits set");
   chk_lock_holds: assert property (o_capture_locked && !det_clr |=> o_capture_locked)
      else $error("capture unlocked without clear");
   chk_unlock_cause: assert property ($fell(o_capture_locked) |-> $past(det_clr))
      else $error("unlock without detect clear");
   chk_lock_irq: assert property ($rose(o_capture_locked) |-> o_maint_irq)
      else $error("capture without interrupt");
   chk_enable_mirror: assert property (i_reg_wr && i_reg_addr == `LTE_ENABLE_OFS ##1
      i_reg_rd && i_reg_addr == `LTE_ENABLE_OFS
      |=> o_reg_rdata == ($past(i_reg_wdata, 2) & `LTE_ERR_MASK))
      else $error("enable readback wrong");
   // main scenarios
   cover property ($rose(o_capture_locked));
   cover property ($fell(o_capture_locked));
   cover property (det_clr);
endmodule // lte_capture_props

bind logical_layer_error_capture lte_capture_props props (.i_clk_sys(i_clk_sys),
   .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .o_reg_rvalid(o_reg_rvalid), .o_maint_irq(o_maint_irq),
   .o_capture_locked(o_capture_locked));

/* File: tb/lte_error_source.sv */
/*
 * packet engine model: one-cycle error and segment pulses on command.
 * assumes the bench drives commands just after a rising edge.
 */
`timescale 1ns/1ps
module lte_error_source
(
   // clock and commands
   input wire logic i_clk_sys,
   input wire logic i_fire,
   input wire logic i_seg,
   input wire logic [3:0] i_kind,
   // pulses, bit 8 goes with detect bit 31
   output logic [8:0] o_err,
   output logic o_seg,
   // packet fields, fresh random every cycle
   output logic [65:0] o_pkt
);
   initial
   begin
      o_err = 9'h000;
      o_seg = 1'b0;
      o_pkt = 66'h0;
   end
   // fields never hold a stale packet between pulses
   always @(posedge i_clk_sys)
   begin
      o_err <= i_fire ? 9'h100 >> i_kind : 9'h000;
      o_seg <= i_seg;
      o_pkt <= 66'({$urandom, $urandom, $urandom});
   end
endmodule // lte_error_source
